// *** rtl/timer_consts.svh ***
// constants for the eight-bit timer/counter: offsets, fields, resets, timing
// assumes 32-bit classic wishbone access and a 100 MHz reference clock
//
// What this block does
// - count wrapping from all-ones to zero raises the timer interrupt condition
// - clock source bit clear: timer mode, one step per instruction cycle
// - a software write to the count blocks counting for two instruction cycles
// - clock source bit set: counter mode, steps on external input edges
// - edge select bit clear counts rising edges, set counts falling edges
// - prescaler serves timer when assign bit clear, watchdog when set, never both
// - the prescaler count itself is neither readable nor writable by software
// - prescaler on the timer divides by 1:2 up to 1:256 in power-of-two steps
// - every wrap sets the overflow flag in the interrupt control register
// - interrupt request is blocked while the overflow enable bit is clear
// - the timer halts during sleep so an overflow cannot wake the core
// - the flag is set on every wrap, whatever the enable bits say
// - interrupt rises at once when global enable, enable and flag are all set
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ***************************************************************
// register offsets (byte addresses)
// ***************************************************************
`define REG_COUNT_OFS   4'h0
`define REG_OPTION_OFS  4'h4
`define REG_IRQCTL_OFS  4'h8

// ***************************************************************
// field positions
// ***************************************************************
`define OPT_RATE_MSB    2
`define OPT_RATE_LSB    0
`define OPT_PSA_BIT     3
`define OPT_EDGE_BIT    4
`define OPT_SRC_BIT     5
`define IRQ_FLAG_BIT    2
`define IRQ_EN_BIT      5
`define IRQ_GIE_BIT     7

// ***************************************************************
// reset values
// ***************************************************************
`define COUNT_RESET     8'h00
`define OPTION_RESET    8'hff
`define IRQCTL_RESET    8'h00
`define COUNT_MAX       8'hff

// ***************************************************************
// timing
// ***************************************************************
`define REF_CLK_NS      10
`define INSTR_CYCLE_NS  40
`define INSTR_DIV_LAST  ((`INSTR_CYCLE_NS / `REF_CLK_NS) - 1)
`define WRITE_INHIBIT   2'd2

`endif

// *** rtl/timer_pkg.sv ***
// types shared by the timer/counter modules
// assumes the constants header is included where the offsets are needed
package timer_pkg;
   typedef logic [7:0] byte_t;
   typedef enum logic {SRC_TIMER, SRC_COUNTER} src_mode_e;
endpackage

// *** rtl/edge_pick.sv ***
// synchroniser and edge selector for the external count input
// assumes smp_in is the one-cycle instruction-cycle enable
`timescale 1ns/1ps
module edge_pick
   import timer_pkg::*;
(
   input  wire logic clk_in,
   input  wire logic resetn_in,
   input  wire logic smp_in,
   input  wire logic pin_in,
   input  wire logic fall_sel_in,
   output logic      ev_out
);
   logic s1, s2, s3;
   logic next_s1, next_s2, next_s3;

   // ***************************************************************
   // two-stage sync, third stage for the edge
   // ***************************************************************
   always_comb begin
      next_s1 = s1;
      next_s2 = s2;
      next_s3 = s3;
      if (smp_in) begin
         next_s1 = pin_in;
         next_s2 = s1;
         next_s3 = s2;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= next_s1;
         s2 <= next_s2;
         s3 <= next_s3;
      end
   end

   assign ev_out = smp_in & (fall_sel_in ? (s3 & ~s2) : (~s3 & s2));

   a_event_on_tick : assert property (@(posedge clk_in) disable iff (!resetn_in)
      ev_out |-> smp_in && (s2 != s3) && (s2 == !fall_sel_in))
      else $error("edge event outside an instruction cycle");
endmodule

// *** rtl/ps_divider.sv ***
// shared eight-bit prescaler, power-of-two tap selected by a rate field
// assumes ev_in is a one-cycle event pulse and clr_in clears the count
`timescale 1ns/1ps
module ps_divider
   import timer_pkg::*;
(
   input  wire logic       clk_in,
   input  wire logic       resetn_in,
   input  wire logic       clr_in,
   input  wire logic       ev_in,
   input  wire logic [2:0] rate_in,
   output logic            tick_out
);
   byte_t cnt;
   byte_t next_cnt;

   function automatic byte_t rate_mask(input logic [2:0] rate);
      rate_mask = 8'hff >> (3'd7 - rate);
   endfunction

   always_comb begin
      next_cnt = cnt;
      if (clr_in)
         next_cnt = 8'h00;
      else if (ev_in)
         next_cnt = cnt + 8'h01;
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in)
         cnt <= 8'h00;
      else
         cnt <= next_cnt;
   end

   assign tick_out = ev_in & ~clr_in & ((cnt & rate_mask(rate_in)) == rate_mask(rate_in));

   // ***************************************************************
   // ratio check helper
   // ***************************************************************
   logic [8:0] seen;
   logic       seen_ok;
   logic [2:0] rate_q;
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         seen    <= 9'h000;
         seen_ok <= 1'b0;
         rate_q  <= 3'h0;
      end else begin
         rate_q <= rate_in;
         if (clr_in || rate_q != rate_in) begin
            seen    <= 9'h000;
            seen_ok <= 1'b0;
         end else if (tick_out) begin
            seen    <= 9'h000;
            seen_ok <= 1'b1;
         end else if (ev_in) begin
            seen <= seen + 9'h001;
         end
      end
   end

   a_ratio_exact : assert property (@(posedge clk_in) disable iff (!resetn_in)
      tick_out && seen_ok && rate_q == rate_in |-> seen + 9'h001 == (9'h002 << rate_in))
      else $error("prescaler ratio differs from the rate field");
endmodule

// *** rtl/eight_bit_timer_counter.sv ***
// eight-bit timer/counter with shared prescaler and wishbone register access
// assumes a classic wishbone master on REF_CLK_IN and synchronous pin inputs
`timescale 1ns/1ps
`include "timer_consts.svh"
module eight_bit_timer_counter
   import timer_pkg::*;
(
   input  wire logic        REF_CLK_IN,
   input  wire logic        RESETN_IN,
   input  wire logic        WB_CYC_IN,
   input  wire logic        WB_STB_IN,
   input  wire logic        WB_WE_IN,
   input  wire logic [3:0]  WB_ADR_IN,
   input  wire logic [3:0]  WB_SEL_IN,
   input  wire logic [31:0] WB_DAT_IN,
   output logic      [31:0] WB_DAT_OUT,
   output logic             WB_ACK_OUT,
   input  wire logic        EXT_COUNT_IN,
   input  wire logic        SLEEP_IN,
   input  wire logic        WDT_TICK_IN,
   output logic             WDT_PRESCALED_OUT,
   output logic             IRQ_OUT
);

   // ***************************************************************
   // state
   // ***************************************************************
   byte_t      timer_count_reg;
   byte_t      option_reg;
   byte_t      irq_control_reg;
   logic [1:0] inhibit;
   logic [1:0] div_cnt;
   byte_t      next_count;
   byte_t      next_option;
   byte_t      next_irqctl;
   logic [1:0] next_inhibit;
   logic [1:0] next_div_cnt;
   logic [31:0] next_dat;
   logic       next_ack;
   logic       next_irq;
   logic       next_wdt;

   logic       icyc;
   logic       bus_req;
   logic       wr_req;
   logic       wr_count;
   logic       wr_option;
   logic       wr_irqctl;
   logic       ext_ev;
   logic       src_ev;
   logic       ps_ev;
   logic       ps_clr;
   logic       ps_tick;
   logic       inc;
   logic       wrap;
   logic       clock_source_select;
   logic       source_edge_select;
   logic       prescaler_assign;
   logic [2:0] rate;
   logic       overflow_flag;
   logic       overflow_irq_enable;
   logic       global_irq_enable;
   src_mode_e  mode;

   assign clock_source_select = option_reg[`OPT_SRC_BIT];
   assign source_edge_select  = option_reg[`OPT_EDGE_BIT];
   assign prescaler_assign    = option_reg[`OPT_PSA_BIT];
   assign rate                = option_reg[`OPT_RATE_MSB:`OPT_RATE_LSB];
   assign overflow_flag       = irq_control_reg[`IRQ_FLAG_BIT];
   assign overflow_irq_enable = irq_control_reg[`IRQ_EN_BIT];
   assign global_irq_enable   = irq_control_reg[`IRQ_GIE_BIT];
   assign mode                = clock_source_select ? SRC_COUNTER : SRC_TIMER;

   // ***************************************************************
   // wishbone decode
   // ***************************************************************
   // address match for one register offset
   function automatic logic addr_hit(input logic [3:0] adr, input logic [3:0] ofs);
      addr_hit = (adr == ofs);
   endfunction

   assign bus_req   = WB_CYC_IN & WB_STB_IN & ~WB_ACK_OUT;
   assign wr_req    = bus_req & WB_WE_IN & WB_SEL_IN[0];
   assign wr_count  = wr_req & addr_hit(WB_ADR_IN, `REG_COUNT_OFS);
   assign wr_option = wr_req & addr_hit(WB_ADR_IN, `REG_OPTION_OFS);
   assign wr_irqctl = wr_req & addr_hit(WB_ADR_IN, `REG_IRQCTL_OFS);

   always_comb begin
      next_ack = bus_req;
      next_dat = WB_DAT_OUT;
      if (bus_req) begin
         // the prescaler count has no address of its own
         case (WB_ADR_IN)
            `REG_COUNT_OFS:  next_dat = {24'h000000, timer_count_reg};
            `REG_OPTION_OFS: next_dat = {24'h000000, option_reg};
            `REG_IRQCTL_OFS: next_dat = {24'h000000, irq_control_reg};
            default:         next_dat = 32'h00000000;
         endcase
      end
   end

   // ***************************************************************
   // instruction-cycle enable, stopped in sleep
   // ***************************************************************
   always_comb begin
      next_div_cnt = div_cnt + 2'd1;
      if (div_cnt == 2'(`INSTR_DIV_LAST))
         next_div_cnt = 2'd0;
   end

   assign icyc = (div_cnt == 2'(`INSTR_DIV_LAST)) & ~SLEEP_IN;

   // ***************************************************************
   // source and prescaler routing
   // ***************************************************************
   edge_pick u_edge (
      .clk_in      (REF_CLK_IN),
      .resetn_in   (RESETN_IN),
      .smp_in      (icyc),
      .pin_in      (EXT_COUNT_IN),
      .fall_sel_in (source_edge_select),
      .ev_out      (ext_ev)
   );

   assign src_ev = (mode == SRC_COUNTER) ? ext_ev : icyc;
   assign ps_ev  = prescaler_assign ? WDT_TICK_IN : src_ev;
   assign ps_clr = wr_option & (WB_DAT_IN[`OPT_PSA_BIT] != prescaler_assign)
                 | wr_count & ~prescaler_assign;

   ps_divider u_ps (
      .clk_in    (REF_CLK_IN),
      .resetn_in (RESETN_IN),
      .clr_in    (ps_clr),
      .ev_in     (ps_ev),
      .rate_in   (rate),
      .tick_out  (ps_tick)
   );

   assign inc  = (prescaler_assign ? src_ev : ps_tick) & (inhibit == 2'd0) & ~wr_count;
   assign wrap = inc & (timer_count_reg == `COUNT_MAX);

   // ***************************************************************
   // count, inhibit and flags
   // ***************************************************************
   always_comb begin
      next_count   = timer_count_reg;
      next_option  = option_reg;
      next_irqctl  = irq_control_reg;
      next_inhibit = inhibit;
      if (wr_count) begin
         next_count   = WB_DAT_IN[7:0];
         next_inhibit = `WRITE_INHIBIT;
      end else begin
         if (inc)
            next_count = timer_count_reg + 8'h01;
         if (icyc && inhibit != 2'd0)
            next_inhibit = inhibit - 2'd1;
      end
      if (wr_option)
         next_option = WB_DAT_IN[7:0];
      if (wr_irqctl)
         next_irqctl = WB_DAT_IN[7:0];
      // set wins over a clearing write
      if (wrap)
         next_irqctl[`IRQ_FLAG_BIT] = 1'b1;
      next_irq = next_irqctl[`IRQ_GIE_BIT] & next_irqctl[`IRQ_EN_BIT]
               & next_irqctl[`IRQ_FLAG_BIT];
      next_wdt = prescaler_assign ? ps_tick : WDT_TICK_IN;
   end

   always_ff @(posedge REF_CLK_IN or negedge RESETN_IN) begin
      if (!RESETN_IN) begin
         timer_count_reg   <= `COUNT_RESET;
         option_reg        <= `OPTION_RESET;
         irq_control_reg   <= `IRQCTL_RESET;
         inhibit           <= 2'd0;
         div_cnt           <= 2'd0;
         WB_DAT_OUT        <= 32'h00000000;
         WB_ACK_OUT        <= 1'b0;
         IRQ_OUT           <= 1'b0;
         WDT_PRESCALED_OUT <= 1'b0;
      end else begin
         timer_count_reg   <= next_count;
         option_reg        <= next_option;
         irq_control_reg   <= next_irqctl;
         inhibit           <= next_inhibit;
         div_cnt           <= next_div_cnt;
         WB_DAT_OUT        <= next_dat;
         WB_ACK_OUT        <= next_ack;
         IRQ_OUT           <= next_irq;
         WDT_PRESCALED_OUT <= next_wdt;
      end
   end

   // ***************************************************************
   // checks
   // ***************************************************************
   default clocking cb @(posedge REF_CLK_IN);
   endclocking
   default disable iff (!RESETN_IN);

   sequence s_count_write;
      wr_count && !SLEEP_IN;
   endsequence

   sequence s_quiet_window;
      (!inc)[*5];
   endsequence

   a_wrap_to_zero : assert property (
      wrap |=> timer_count_reg == 8'h00 && overflow_flag)
      else $error("wrap did not give zero count with flag");

   a_timer_step : assert property (
      mode == SRC_TIMER && prescaler_assign && icyc && inhibit == 2'd0 && !wr_count
      |=> timer_count_reg == $past(timer_count_reg) + 8'h01)
      else $error("timer mode missed an instruction-cycle step");

   a_write_hold : assert property (
      s_count_write |=> s_quiet_window)
      else $error("count advanced within two cycles of a write");

   a_counter_src : assert property (
      inc && mode == SRC_COUNTER && prescaler_assign |-> ext_ev)
      else $error("counter mode stepped without an input edge");

   a_psa_owner : assert property (
      prescaler_assign && !src_ev && !wr_count
      |=> timer_count_reg == $past(timer_count_reg))
      else $error("watchdog ticks reached the timer count");

   a_flag_always : assert property (
      wrap && !overflow_irq_enable |=> overflow_flag)
      else $error("flag not set on wrap with interrupt disabled");

   a_irq_masked : assert property (
      !overflow_irq_enable && !wr_irqctl |=> !IRQ_OUT)
      else $error("interrupt seen with enable clear");

   a_flag_sticky : assert property (
      overflow_flag && !wr_irqctl |=> overflow_flag)
      else $error("flag cleared without software");

   a_sleep_halt : assert property (
      SLEEP_IN && !wr_count |=> timer_count_reg == $past(timer_count_reg))
      else $error("count moved during sleep");

   a_irq_prompt : assert property (
      global_irq_enable && overflow_irq_enable && overflow_flag && !wr_irqctl |=> IRQ_OUT)
      else $error("interrupt late with all enables set");

   a_ack_once : assert property (
      WB_ACK_OUT |=> !WB_ACK_OUT)
      else $error("ack held for more than one cycle");

   // ***************************************************************
   // bus handshake and register loads
   // ***************************************************************
   a_ack_prompt : assert property (
      bus_req |=> WB_ACK_OUT)
      else $error("ack missing one cycle after a request");

   a_read_count : assert property (
      bus_req && !WB_WE_IN && WB_ADR_IN == `REG_COUNT_OFS
      |=> WB_DAT_OUT == {24'h000000, $past(timer_count_reg)})
      else $error("count read returned a wrong value");

   a_count_load : assert property (
      wr_count |=> timer_count_reg == byte_t'($past(WB_DAT_IN)))
      else $error("count write did not load the count");

   a_option_load : assert property (
      wr_option |=> option_reg == byte_t'($past(WB_DAT_IN)))
      else $error("option write did not load the option");

   a_inhibit_load : assert property (
      wr_count |=> inhibit == `WRITE_INHIBIT)
      else $error("count write did not start the inhibit");

   // ***************************************************************
   // prescaler ownership and interrupt path
   // ***************************************************************
   a_ps_restart : assert property (
      ps_clr |=> u_ps.cnt == 8'h00)
      else $error("prescaler not restarted on owner change");

   a_wdt_raw : assert property (
      !prescaler_assign |=> WDT_PRESCALED_OUT == $past(WDT_TICK_IN))
      else $error("watchdog tick not passed through undivided");

   a_wdt_owned : assert property (
      prescaler_assign && !WDT_TICK_IN |=> !WDT_PRESCALED_OUT)
      else $error("watchdog output without a watchdog tick");

   a_flag_cause : assert property (
      $rose(overflow_flag) && !$past(wr_irqctl) |-> timer_count_reg == 8'h00)
      else $error("flag set without a wrap to zero");

   a_irq_no_gie : assert property (
      !global_irq_enable && !wr_irqctl |=> !IRQ_OUT)
      else $error("interrupt seen with global enable clear");

   a_irq_follow : assert property (
      !overflow_flag && !wr_irqctl && !wrap |=> !IRQ_OUT)
      else $error("interrupt seen with flag clear");
endmodule

// *** sim/pulse_source.sv ***
// external pulse source model driving the count input pin
// assumes the caller runs on the same reference clock as the block
`timescale 1ns/1ps
module pulse_source (
   input  wire logic clk_in,
   output logic      pin_out
);
   // ***************************************************************
   // pin driver
   // ***************************************************************
   initial begin
      pin_out = 1'b0;
   end

   // each level held for half clocks, at least two instruction cycles
   task automatic toggle(input int n, input int half);
      for (int i = 0; i < n; i++) begin
         @(posedge clk_in);
         pin_out <= ~pin_out;
         repeat (half - 1) @(posedge clk_in);
      end
   endtask
endmodule

// *** sim/eight_bit_timer_counter_tb.sv ***
// self-checking bench for the eight-bit timer/counter
// assumes the design files and the constants header are compiled first
`timescale 1ns/1ps
`include "timer_consts.svh"
module eight_bit_timer_counter_tb;
   import timer_pkg::*;
   typedef struct {byte_t opt; byte_t start; int k;} row_s;
   logic        clk = 1'b0;
   logic        rst_n, cyc, stb, we, sleep, tick, ack, wdt_out, irq, pin;
   logic [3:0]  adr, sel;
   logic [31:0] wdat, rdat, q;
   int          n_mismatch = 0;
   int          cmp_count = 0;
   int          n_wdt = 0;
   int          div;
   byte_t       e, d;
   byte_t       c_opt[3] = '{8'h28, 8'h38, 8'h20};
   int          c_tog[3] = '{7, 7, 15};
   row_s        rows[9] = '{'{8'h08, 8'hfd, 12}, '{8'h00, 8'hfe, 5}, '{8'h01, 8'h20, 5},
                            '{8'h02, 8'h20, 5}, '{8'h03, 8'h20, 5}, '{8'h04, 8'h20, 5},
                            '{8'h05, 8'h20, 5}, '{8'h06, 8'h20, 5}, '{8'h07, 8'h20, 5}};

   always #5 clk = ~clk;
   always @(posedge clk) if (wdt_out === 1'b1) n_wdt <= n_wdt + 1;

   eight_bit_timer_counter eight_bit_timer_counter_i (
      .REF_CLK_IN(clk), .RESETN_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
      .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
      .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .EXT_COUNT_IN(pin), .SLEEP_IN(sleep),
      .WDT_TICK_IN(tick), .WDT_PRESCALED_OUT(wdt_out), .IRQ_OUT(irq));
   pulse_source pulse_source_i (.clk_in(clk), .pin_out(pin));

   // ***************************************************************
   // shared tasks
   // ***************************************************************
   task automatic test_done;
      $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // classic single cycle, held until ack is sampled high
   task automatic wb_xfer(input logic w, input logic [3:0] a, input byte_t dt,
                          input logic [3:0] s, output logic [31:0] r);
      int n;
      @(posedge clk);
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= s; wdat <= {24'h0, dt};
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      r = rdat;
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      if (ack !== 1'b1) begin
         n_mismatch++;
         test_done();
      end
   endtask

   task automatic wr(input logic [3:0] a, input byte_t dt, input logic [3:0] s = 4'hf);
      logic [31:0] r;
      wb_xfer(1'b1, a, dt, s, r);
   endtask

   task automatic rd(input logic [3:0] a, output logic [31:0] r);
      wb_xfer(1'b0, a, 8'h00, 4'hf, r);
   endtask

   task automatic ticks(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge clk); tick <= 1'b1;
         @(posedge clk); tick <= 1'b0;
         repeat (3) @(posedge clk);
      end
      repeat (4) @(posedge clk);
   endtask

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 4'h0; sel = 4'h0;
      wdat = 32'h0; sleep = 1'b0; tick = 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      rd(`REG_COUNT_OFS, q);  check("count reset", q, {24'h0, `COUNT_RESET});
      rd(`REG_OPTION_OFS, q); check("option reset", q, {24'h0, `OPTION_RESET});
      rd(`REG_IRQCTL_OFS, q); check("irqctl reset", q, {24'h0, `IRQCTL_RESET});
      check("irq reset", {31'h0, irq}, 32'h0);
      // timer mode, every rate and the undivided case
      for (int i = 0; i < 9; i++) begin
         div = rows[i].opt[3] ? 1 : 2 << rows[i].opt[2:0];
         wr(`REG_OPTION_OFS, rows[i].opt);
         wr(`REG_COUNT_OFS, rows[i].start);
         repeat (4 * div * rows[i].k + 2 * div - 2) @(posedge clk);
         rd(`REG_COUNT_OFS, q);
         e = rows[i].start + byte_t'(rows[i].k) - (rows[i].opt[3] ? 8'h02 : 8'h00);
         d = q[7:0] - e + 8'h01;
         check("timer count", {31'h0, d <= 8'h02}, 32'h1);
      end
      // counter mode: rising, falling, rising with 1:2
      for (int j = 0; j < 3; j++) begin
         wr(`REG_OPTION_OFS, c_opt[j]);
         wr(`REG_COUNT_OFS, 8'h00);
         repeat (20) @(posedge clk);
         pulse_source_i.toggle(c_tog[j], 8);
         repeat (20) @(posedge clk);
         rd(`REG_COUNT_OFS, q);
         check("counter count", q, 32'h4);
      end
      // sleep halts, narrow write and unmapped place ignored
      wr(`REG_OPTION_OFS, 8'h08);
      @(posedge clk); sleep <= 1'b1;
      wr(`REG_COUNT_OFS, 8'h55);
      wr(`REG_COUNT_OFS, 8'haa, 4'he);
      wr(4'hc, 8'h33);
      repeat (200) @(posedge clk);
      rd(`REG_COUNT_OFS, q); check("sleep count", q, 32'h55);
      rd(4'hc, q);           check("unmapped read", q, 32'h0);
      @(posedge clk); sleep <= 1'b0;
      // write inhibit, wrap flag, masking
      wr(`REG_IRQCTL_OFS, 8'h00);
      wr(`REG_COUNT_OFS, 8'hff);
      rd(`REG_IRQCTL_OFS, q); check("flag early", {31'h0, q[2]}, 32'h0);
      rd(`REG_COUNT_OFS, q);  check("count held", q, 32'hff);
      repeat (20) @(posedge clk);
      rd(`REG_IRQCTL_OFS, q); check("flag wrap", {31'h0, q[2]}, 32'h1);
      check("irq masked", {31'h0, irq}, 32'h0);
      wr(`REG_IRQCTL_OFS, 8'ha4);
      @(negedge clk); check("irq on", {31'h0, irq}, 32'h1);
      wr(`REG_IRQCTL_OFS, 8'h84);
      @(negedge clk); check("irq no enable", {31'h0, irq}, 32'h0);
      wr(`REG_IRQCTL_OFS, 8'ha0);
      @(negedge clk); check("irq cleared", {31'h0, irq}, 32'h0);
      // prescaler ownership seen on the watchdog side
      wr(`REG_OPTION_OFS, 8'h08);
      n_wdt = 0;
      ticks(4); check("wdt divided", n_wdt, 32'h2);
      wr(`REG_OPTION_OFS, 8'h00);
      n_wdt = 0;
      ticks(4); check("wdt raw", n_wdt, 32'h4);
      // second reset mid-run
      @(posedge clk); rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rd(`REG_OPTION_OFS, q); check("option re-reset", q, {24'h0, `OPTION_RESET});
      test_done();
   end
endmodule
